// ==== logic/tpfc_gen.sv ====
// test pattern frame generator: config registers, frame timing, fifo
// assumes register port and tx stream are synchronous to CLK_SYS
// Functional notes
// - virtual channel from bits 7:6 goes into every packet header.
// - data type from bits 5:0, reset 0x24, goes into headers.
// - line length is 16-bit byte count, default 1920.
// - bar size sets byte length of all bars but the last.
// - last bar takes the remaining bytes of the line.
// - active lines per frame from 16-bit value, default 480.
// - total lines per frame sizes the frame, low byte resets 0x0D.
// - each 16-bit value is two byte registers, high byte first.
// - frames start only while enable bit is set; a started frame runs to frame end.
// - line period is a 16-bit count of 10 ns units.
// - back porch blank lines follow frame start before video.
`timescale 1ns/1ps
module tpfc_fifo #(
  parameter int W = 10,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  // no reset on the memory; only written words are ever read
  logic [W-1:0]  mem [D];
  // count one bit wider than the pointers so full differs from empty
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  wire           do_wr = in_valid && in_ready;
  wire           do_rd = out_valid && out_ready;
  assign in_ready  = cnt_reg != (AW+1)'(D);
  assign out_valid = cnt_reg != '0;
  assign out_data  = mem[rd_reg];
  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem[wr_reg] <= in_data;
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (do_wr)
        wr_reg <= (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
      if (do_rd)
        rd_reg <= (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

module tpfc_gen #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic       CLK_SYS,
  input  wire logic       ARST_N,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WE,
  input  wire logic       REG_RE,
  output logic [7:0]      REG_RDATA,
  output logic            GEN_BUSY,
  output logic            TX_VALID,
  input  wire logic       TX_READY,
  output logic [7:0]      TX_DATA,
  output logic [1:0]      TX_KIND
);
  typedef enum logic [1:0] {S_IDLE, S_FS, S_LINE, S_FE} tpfc_state_e;

  function automatic logic [7:0] rst_val(input logic [7:0] a);
    case (a)
      tpfc_pkg::A_CTRL:   rst_val = tpfc_pkg::R_CTRL;
      tpfc_pkg::A_CFG:    rst_val = tpfc_pkg::R_CFG;
      tpfc_pkg::A_PKT:    rst_val = tpfc_pkg::R_PKT;
      tpfc_pkg::A_LINE_H: rst_val = tpfc_pkg::R_LINE_H;
      tpfc_pkg::A_LINE_L: rst_val = tpfc_pkg::R_LINE_L;
      tpfc_pkg::A_BAR_H:  rst_val = tpfc_pkg::R_BAR_H;
      tpfc_pkg::A_BAR_L:  rst_val = tpfc_pkg::R_BAR_L;
      tpfc_pkg::A_ACT_H:  rst_val = tpfc_pkg::R_ACT_H;
      tpfc_pkg::A_ACT_L:  rst_val = tpfc_pkg::R_ACT_L;
      tpfc_pkg::A_TOT_H:  rst_val = tpfc_pkg::R_TOT_H;
      tpfc_pkg::A_TOT_L:  rst_val = tpfc_pkg::R_TOT_L;
      tpfc_pkg::A_PD_H:   rst_val = tpfc_pkg::R_PD_H;
      tpfc_pkg::A_PD_L:   rst_val = tpfc_pkg::R_PD_L;
      tpfc_pkg::A_VBP:    rst_val = tpfc_pkg::R_VBP;
      tpfc_pkg::A_VFP:    rst_val = tpfc_pkg::R_VFP;
      default:            rst_val = 8'h00;
    endcase
  endfunction

  // byte pair, high byte at the lower offset
  function automatic logic [15:0] pair(input logic [7:0] hi,
                                       input logic [7:0] lo);
    pair = {hi, lo};
  endfunction

  // header word: kind code plus the packet identifier byte
  function automatic logic [9:0] hdr_word(input logic [1:0] kind,
                                          input logic [7:0] id);
    hdr_word = {kind, id};
  endfunction

  logic [7:0]  regs [16];
  logic [7:0]  rdata_reg;
  tpfc_state_e st_reg;
  tpfc_state_e st_next;
  logic [16:0] tmr_reg;
  logic [15:0] line_reg;
  logic [15:0] left_reg;
  logic [15:0] pos_reg;
  logic [2:0]  bar_reg;
  logic        hdr_reg;
  logic        push;
  logic [9:0]  push_word;
  logic        in_ready;
  logic [9:0]  tx_word;

  wire         mapped  = REG_ADDR != 8'h00 && REG_ADDR <= tpfc_pkg::A_LAST;
  wire [3:0]   ridx    = REG_ADDR[3:0];
  wire         gen_on  = regs[tpfc_pkg::A_CTRL[3:0]][tpfc_pkg::ENABLE_BIT];
  wire [7:0]   pkt     = regs[tpfc_pkg::A_PKT[3:0]];
  wire [1:0]   bar_count_sel =
    regs[tpfc_pkg::A_CFG[3:0]][tpfc_pkg::BARS_HI:tpfc_pkg::BARS_LO];
  wire [1:0]   gen_virtual_channel = pkt[7:6];
  wire [5:0]   gen_data_type       = pkt[5:0];
  wire [15:0]  gen_line_bytes  = pair(regs[tpfc_pkg::A_LINE_H[3:0]],
                                      regs[tpfc_pkg::A_LINE_L[3:0]]);
  wire [15:0]  gen_bar_bytes   = pair(regs[tpfc_pkg::A_BAR_H[3:0]],
                                      regs[tpfc_pkg::A_BAR_L[3:0]]);
  wire [15:0]  gen_active_lines = pair(regs[tpfc_pkg::A_ACT_H[3:0]],
                                       regs[tpfc_pkg::A_ACT_L[3:0]]);
  wire [15:0]  gen_frame_lines = pair(regs[tpfc_pkg::A_TOT_H[3:0]],
                                      regs[tpfc_pkg::A_TOT_L[3:0]]);
  wire [15:0]  gen_line_period = pair(regs[tpfc_pkg::A_PD_H[3:0]],
                                      regs[tpfc_pkg::A_PD_L[3:0]]);
  wire [7:0]   gen_back_porch_lines = regs[tpfc_pkg::A_VBP[3:0]];

  // front porch is whatever total leaves after active and back porch
  wire [16:0]  act_end   = 17'(gen_back_porch_lines) + 17'(gen_active_lines);
  wire [16:0]  frame_len = (17'(gen_frame_lines) > act_end) ?
                           17'(gen_frame_lines) : act_end;
  wire         line_act  = 17'(line_reg) >= 17'(gen_back_porch_lines)
                        && 17'(line_reg) < act_end;
  wire         last_line = 17'(line_reg) + 17'h1 >= frame_len;
  wire [2:0]   last_bar  = 3'((4'h1 << bar_count_sel) - 4'h1);
  wire         tmr_done  = tmr_reg >= 17'(gen_line_period);
  wire         bytes_done = !line_act || (!hdr_reg && left_reg == '0);
  wire         line_end  = tmr_done && bytes_done;
  wire         bar_wrap  = bar_reg != last_bar
                        && pos_reg + 16'h1 >= gen_bar_bytes;
  // the last bar never wraps, so it soaks up the rest of the line
  wire [2:0]   bar_next  = bar_wrap ? bar_reg + 3'h1 : bar_reg;
  wire [15:0]  pos_next  = bar_wrap ? '0 : pos_reg + 16'h1;
  // timer may overshoot the period by less than one step of units
  wire [16:0]  tmr_step  = tmr_reg + tpfc_pkg::UNITS_PER_CLK;
  wire         line_restart = st_reg != S_LINE || line_end;
  wire [15:0]  line_next = (st_reg == S_LINE && !last_line) ?
                           line_reg + 16'h1 : '0;
  // one identifier byte shared by all three header kinds
  wire [7:0]   hdr_id    = {gen_virtual_channel, gen_data_type};
  // unmapped offsets read back as zero
  wire [7:0]   rd_byte   = mapped ? regs[ridx] : 8'h00;

  assign push = (st_reg == S_FS || st_reg == S_FE)
             || (st_reg == S_LINE && line_act
                 && (hdr_reg || left_reg != '0));
  assign push_word =
    (st_reg == S_FS) ?
      hdr_word(tpfc_pkg::K_FS, hdr_id) :
    (st_reg == S_FE) ?
      hdr_word(tpfc_pkg::K_FE, hdr_id) :
    hdr_reg ?
      hdr_word(tpfc_pkg::K_LS, hdr_id) :
    {tpfc_pkg::K_DATA, 5'h00, bar_reg};
  wire         pushed = push && in_ready;

  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      S_IDLE:
        if (gen_on)
          st_next = S_FS;
      S_FS:
        if (pushed)
          st_next = S_LINE;
      S_LINE:
        if (line_end && last_line)
          st_next = S_FE;
      S_FE:
        if (pushed)
          st_next = gen_on ? S_FS : S_IDLE;
      default:
        st_next = S_IDLE;
    endcase
  end

  // register port; a read on the edge of a write sees the old byte
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      for (int i = 0; i < 16; i++)
        regs[i] <= rst_val(8'(i));
    end
    else if (REG_WE && mapped)
    begin
      regs[ridx] <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      rdata_reg <= 8'h00;
    else if (REG_RE)
      rdata_reg <= rd_byte;
  end

  // state register kept apart from the line counters
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      st_reg <= S_IDLE;
    else
      st_reg <= st_next;
  end

  // timing; config changes mid-frame take effect at once, except line length, loaded at each line start
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      tmr_reg  <= '0;
      line_reg <= '0;
      left_reg <= '0;
      pos_reg  <= '0;
      bar_reg  <= '0;
      hdr_reg  <= 1'b0;
    end
    else if (line_restart)
    begin
      tmr_reg  <= '0;
      left_reg <= gen_line_bytes;
      pos_reg  <= '0;
      bar_reg  <= '0;
      hdr_reg  <= 1'b1;
      line_reg <= line_next;
    end
    else
    begin
      if (!tmr_done)
        tmr_reg <= tmr_step;
      if (pushed && hdr_reg)
        hdr_reg <= 1'b0;
      else if (pushed)
      begin
        left_reg <= left_reg - 16'h1;
        pos_reg  <= pos_next;
        bar_reg  <= bar_next;
      end
    end
  end

  // fifo lets a stalled sink hold back pushes without losing words

  tpfc_fifo #(
    .W(10),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .arst_n    (ARST_N),
    .in_valid  (push),
    .in_ready  (in_ready),
    .in_data   (push_word),
    .out_valid (TX_VALID),
    .out_ready (TX_READY),
    .out_data  (tx_word)
  );

  assign TX_KIND   = tx_word[9:8];
  assign TX_DATA   = tx_word[7:0];
  assign REG_RDATA = rdata_reg;
  assign GEN_BUSY  = st_reg != S_IDLE;
endmodule

// ==== logic/tpfc_pkg.sv ====
// constants for the test pattern frame generator
// assumes byte-wide register port, 20 MHz system clock
package tpfc_pkg;
  localparam logic [7:0] A_CTRL   = 8'h01;
  localparam logic [7:0] A_CFG    = 8'h02;
  localparam logic [7:0] A_PKT    = 8'h03;
  localparam logic [7:0] A_LINE_H = 8'h04;
  localparam logic [7:0] A_LINE_L = 8'h05;
  localparam logic [7:0] A_BAR_H  = 8'h06;
  localparam logic [7:0] A_BAR_L  = 8'h07;
  localparam logic [7:0] A_ACT_H  = 8'h08;
  localparam logic [7:0] A_ACT_L  = 8'h09;
  localparam logic [7:0] A_TOT_H  = 8'h0A;
  localparam logic [7:0] A_TOT_L  = 8'h0B;
  localparam logic [7:0] A_PD_H   = 8'h0C;
  localparam logic [7:0] A_PD_L   = 8'h0D;
  localparam logic [7:0] A_VBP    = 8'h0E;
  localparam logic [7:0] A_VFP    = 8'h0F;
  localparam logic [7:0] A_LAST   = 8'h0F;
  localparam logic [7:0] R_CTRL   = 8'h00;
  localparam logic [7:0] R_CFG    = 8'h33;
  localparam logic [7:0] R_PKT    = 8'h24;
  localparam logic [7:0] R_LINE_H = 8'h07;
  localparam logic [7:0] R_LINE_L = 8'h80;
  localparam logic [7:0] R_BAR_H  = 8'h00;
  localparam logic [7:0] R_BAR_L  = 8'hF0;
  localparam logic [7:0] R_ACT_H  = 8'h01;
  localparam logic [7:0] R_ACT_L  = 8'hE0;
  localparam logic [7:0] R_TOT_H  = 8'h02;
  localparam logic [7:0] R_TOT_L  = 8'h0D;
  localparam logic [7:0] R_PD_H   = 8'h0C;
  localparam logic [7:0] R_PD_L   = 8'h67;
  localparam logic [7:0] R_VBP    = 8'h21;
  localparam logic [7:0] R_VFP    = 8'h0A;
  localparam int ENABLE_BIT = 0;
  localparam int BARS_HI    = 5;
  localparam int BARS_LO    = 4;
  localparam logic [1:0] K_DATA = 2'h0;
  localparam logic [1:0] K_FS   = 2'h1;
  localparam logic [1:0] K_FE   = 2'h2;
  localparam logic [1:0] K_LS   = 2'h3;
  localparam int LINE_UNIT_NS = 10;
  localparam int CLK_NS       = 50;
  localparam logic [16:0] UNITS_PER_CLK = 17'(CLK_NS / LINE_UNIT_NS);
endpackage

// ==== verification/tb_top.sv ====
// bench for the pattern frame generator: registers and frame stream
// assumes tpfc_gen, tpfc_sink and the bound checker are compiled
`timescale 1ns/1ps
module tb_top;
  logic       clk_sys = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       we = 1'b0;
  logic       re = 1'b0;
  logic       stall = 1'b0;
  logic       slow = 1'b0;
  logic [7:0] rdata, tx_data;
  logic       busy, tx_valid, tx_ready;
  logic [1:0] tx_kind;
  int         n_fail = 0;
  int         n_tests = 0;
  int         cyc = 0;
  logic [9:0] q[$];
  int         tq[$];
  logic [7:0] rst_tab [16] = '{8'h00, 8'h00, 8'h33, 8'h24, 8'h07, 8'h80,
    8'h00, 8'hF0, 8'h01, 8'hE0, 8'h02, 8'h0D, 8'h0C, 8'h67, 8'h21, 8'h0A};
  // short geometry: 11-byte lines, 3-byte bars, 2 of 4 lines active
  logic [7:0] cfg_tab [11] = '{8'h00, 8'h0B, 8'h00, 8'h03, 8'h00, 8'h02,
    8'h00, 8'h04, 8'h00, 8'h20, 8'h01};
  tpfc_gen #(.FIFO_DEPTH(16)) dut (.CLK_SYS(clk_sys), .ARST_N(arst_n),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WE(we), .REG_RE(re),
    .REG_RDATA(rdata), .GEN_BUSY(busy), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .TX_DATA(tx_data), .TX_KIND(tx_kind));
  tpfc_sink far (.clk(clk_sys), .arst_n(arst_n), .stall(stall),
    .slow(slow), .ready(tx_ready));
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (tx_valid && tx_ready) q.push_back({tx_kind, tx_data});
    if (tx_valid && tx_ready) tq.push_back(cyc);
    if (cyc > 20000)
    begin
      n_fail++;
      finish_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge clk_sys);
    we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    addr = a;
    re = 1'b1;
    @(negedge clk_sys);
    re = 1'b0;
    check(rdata, exp);
  endtask
  task automatic t_regs();
    for (int a = 0; a < 16; a++)
      rd(8'(a), rst_tab[a]);
    rd(8'h10, 8'h00);
    wr(tpfc_pkg::A_LINE_H, 8'hA5);
    rd(tpfc_pkg::A_LINE_H, 8'hA5);
    rd(tpfc_pkg::A_LINE_L, 8'h80);
    $display("test regs done");
  endtask
  // st: sink slow and stalled long enough to fill the fifo
  task automatic t_frame(input logic [1:0] sel, input logic st);
    int nb;
    int j;
    int lim;
    logic [9:0] exp;
    nb = 1 << sel;
    q.delete();
    tq.delete();
    slow = st;
    wr(tpfc_pkg::A_CFG, {2'b00, sel, 4'h3});
    wr(tpfc_pkg::A_CTRL, 8'h01);
    wr(tpfc_pkg::A_CTRL, 8'h00);
    stall = st;
    repeat (30) @(negedge clk_sys);
    stall = 1'b0;
    lim = 0;
    while ((busy !== 1'b0 || tx_valid !== 1'b0) && lim < 2000)
    begin
      @(negedge clk_sys);
      lim++;
    end
    repeat (20) @(negedge clk_sys);
    check(q.size(), 26);
    check(q[0], {tpfc_pkg::K_FS, 8'hC5});
    check(q[25], {tpfc_pkg::K_FE, 8'hC5});
    for (int k = 0; k < 24; k++)
    begin
      j = (k % 12 - 1) / 3;
      exp = {tpfc_pkg::K_DATA, 8'(j < nb ? j : nb - 1)};
      check(q[k+1], k % 12 == 0 ? {tpfc_pkg::K_LS, 8'hC5} : exp);
    end
    if (!st)
      check(tq[1] - tq[0] >= 7 && tq[1] - tq[0] <= 13, 1);
    $display("test frame %0d done", sel);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge clk_sys);
    arst_n = 1'b1;
    t_regs();
    for (int a = 4; a < 15; a++)
      wr(8'(a), cfg_tab[a-4]);
    wr(tpfc_pkg::A_PKT, 8'hC5);
    for (int s = 0; s < 4; s++)
      t_frame(2'(s), s[0]);
    finish_test();
  end
endmodule

// ==== verification/tpfc_checker.sv ====
// port checks for the pattern frame generator
// assumes bound onto tpfc_gen; single clock domain
`timescale 1ns/1ps
module tpfc_checker (
  input wire logic       CLK_SYS,
  input wire logic       ARST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WE,
  input wire logic       REG_RE,
  input wire logic [7:0] REG_RDATA,
  input wire logic       GEN_BUSY,
  input wire logic       TX_VALID,
  input wire logic       TX_READY,
  input wire logic [7:0] TX_DATA,
  input wire logic [1:0] TX_KIND
);
  logic [7:0] pkt_reg;
  wire        hdr = TX_VALID && TX_KIND != tpfc_pkg::K_DATA;
  // shadow of the header byte; only valid if changed while idle
  always_ff @(posedge CLK_SYS or negedge ARST_N)
    if (!ARST_N) pkt_reg <= tpfc_pkg::R_PKT;
    else if (REG_WE && REG_ADDR == tpfc_pkg::A_PKT) pkt_reg <= REG_WDATA;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID
    && $stable(TX_DATA) && $stable(TX_KIND)) else $error("word dropped");
  a_hdr_pkt: assert property (hdr |-> TX_DATA == pkt_reg)
    else $error("header byte wrong");
  a_rd_pkt: assert property (REG_RE && REG_ADDR == tpfc_pkg::A_PKT
    |=> REG_RDATA == $past(pkt_reg)) else $error("packet reg read wrong");
  a_unmap_rd: assert property (REG_RE && (REG_ADDR == 8'h00
    || REG_ADDR > tpfc_pkg::A_LAST) |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_en_start: assert property (REG_WE && REG_ADDR == tpfc_pkg::A_CTRL
    && REG_WDATA[0] && !GEN_BUSY && !TX_VALID |-> ##[1:3] TX_VALID
    && TX_KIND == tpfc_pkg::K_FS) else $error("no frame start");
  a_data_idx: assert property (TX_VALID && TX_KIND == 2'h0
    |-> TX_DATA < 8'h08) else $error("bar index out of range");
  a_rst_quiet: assert property ($rose(ARST_N) |-> !TX_VALID
    && !GEN_BUSY && REG_RDATA == 8'h00) else $error("not quiet after reset");
  a_idle_quiet: assert property (!GEN_BUSY && !TX_VALID && !REG_WE
    && !$past(REG_WE) |=> !TX_VALID) else $error("output while idle");
endmodule
bind tpfc_gen tpfc_checker u_chk (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE),
  .REG_RE(REG_RE), .REG_RDATA(REG_RDATA), .GEN_BUSY(GEN_BUSY),
  .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_DATA(TX_DATA),
  .TX_KIND(TX_KIND));

// ==== verification/tpfc_sink.sv ====
// far-end consumer of the generated packet stream
// assumes one clock; ready moves only after a rising edge or a stall or slow change
`timescale 1ns/1ps
module tpfc_sink (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic stall,
  input  wire logic slow,
  output logic      ready
);
  logic phase_reg;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) phase_reg <= 1'b0;
    else phase_reg <= !phase_reg;
  // slow mode takes a word only every other cycle, like a busy lane
  assign ready = !stall && (!slow || phase_reg);
endmodule
